/* hw/wws_top.sv */
// Window watchdog supervisor: checks processor triggers against a
// lower boundary and a timeout and pulls an open-drain reset low.
// Assumes straps are static while the supervisor runs; pins are async.
//
// How it works
// - A free-running oscillator samples trigger rising edges, acting on each at its next tick.
// - With ratio select high the lower boundary is the window over 124.9, 127.7 or 64.5.
// - With ratio select low the lower boundary is the window over 31.8, 32 or 25.8.
// - The timeout strap picks about 0.25 s or 2.5 s, or a capacitor sets the window.
// - Capacitor mode with ratio low keeps the boundary between window/28.7 and window/23.5.
// - Capacitor mode with ratio high keeps the boundary between window/92.7 and window/51.6.
// - Exactly two ratio settings exist, picked by the ratio strap, each a window fraction set by the timeout strap and capacitor mode.
// - A missing trigger before timeout or a trigger inside the lower boundary is a violation.
// - Each recognised trigger edge restarts the timers and a new lower boundary.
// - After reset release the first window has no lower check until the first edge.
`timescale 1ns/1ps

module wws_top
	import wws_pkg::*;
#(
	parameter int NORM_DIV     = OSC_DIV,
	parameter int CAP_DIV      = CAP_OSC_DIV,
	parameter int SHORT_TICKS  = WIN_SHORT_TICKS,
	parameter int LONG_TICKS   = WIN_LONG_TICKS,
	parameter int CAP_TICKS    = CAP_WIN_TICKS,
	parameter int HOLD_TICKS   = RST_HOLD_TICKS
)
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic watchdog_trigger_in,
	input  wire logic timeout_select,
	input  wire logic window_ratio_select,
	input  wire logic cap_mode,
	input  wire logic reset_pin_in,
	output logic      reset_pin_out,
	output logic      reset_pin_oe_n,
	output logic      violation_early,
	output logic      violation_late,
	output logic      first_window
);

	// Lower boundaries in ticks, ratios kept times ten
	localparam int LOW_HI_SHORT = (SHORT_TICKS * 10) / RATIO_HI_SHORT;
	localparam int LOW_HI_LONG  = (LONG_TICKS * 10) / RATIO_HI_LONG;
	localparam int LOW_HI_CAP   = (CAP_TICKS * 10) / RATIO_HI_CAP;
	localparam int LOW_LO_SHORT = (SHORT_TICKS * 10) / RATIO_LO_SHORT;
	localparam int LOW_LO_LONG  = (LONG_TICKS * 10) / RATIO_LO_LONG;
	localparam int LOW_LO_CAP   = (CAP_TICKS * 10) / RATIO_LO_CAP;

	initial
	begin
		if (SHORT_TICKS < 2 || LONG_TICKS < 2 || CAP_TICKS < 2 || HOLD_TICKS < 1)
			$error("wws_top: window or hold count too small");
		if (SHORT_TICKS >= 2**CNT_W || LONG_TICKS >= 2**CNT_W ||
			CAP_TICKS >= 2**CNT_W || HOLD_TICKS >= 2**CNT_W)
			$error("wws_top: count exceeds counter width");
		if (LOW_LO_CAP * RATIO_LO_CAP_MIN > CAP_TICKS * 10 ||
			LOW_LO_CAP * RATIO_LO_CAP_MAX < (CAP_TICKS * 10) - RATIO_LO_CAP_MAX)
			$error("wws_top: capacitor lower boundary off span, ratio low");
		if (LOW_HI_CAP * RATIO_HI_CAP_MIN > CAP_TICKS * 10 ||
			LOW_HI_CAP * RATIO_HI_CAP_MAX < (CAP_TICKS * 10) - RATIO_HI_CAP_MAX)
			$error("wws_top: capacitor lower boundary off span, ratio high");
	end

	localparam logic [CNT_W-1:0] C_LOW_HI_SHORT = CNT_W'(LOW_HI_SHORT);
	localparam logic [CNT_W-1:0] C_LOW_HI_LONG  = CNT_W'(LOW_HI_LONG);
	localparam logic [CNT_W-1:0] C_LOW_HI_CAP   = CNT_W'(LOW_HI_CAP);
	localparam logic [CNT_W-1:0] C_LOW_LO_SHORT = CNT_W'(LOW_LO_SHORT);
	localparam logic [CNT_W-1:0] C_LOW_LO_LONG  = CNT_W'(LOW_LO_LONG);
	localparam logic [CNT_W-1:0] C_LOW_LO_CAP   = CNT_W'(LOW_LO_CAP);
	localparam logic [CNT_W-1:0] C_WIN_SHORT    = CNT_W'(SHORT_TICKS - 1);
	localparam logic [CNT_W-1:0] C_WIN_LONG     = CNT_W'(LONG_TICKS - 1);
	localparam logic [CNT_W-1:0] C_WIN_CAP      = CNT_W'(CAP_TICKS - 1);
	localparam logic [CNT_W-1:0] C_HOLD_LAST    = CNT_W'(HOLD_TICKS - 1);

	wws_core_type     r;
	wws_core_type     next_r;
	logic             tick;
	logic             trig_edge;
	logic [CNT_W-1:0] win_last;
	logic [CNT_W-1:0] low_bound;

	wws_tick #(
		.NORM_DIV (NORM_DIV),
		.CAP_DIV  (CAP_DIV)
	) u_tick (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.cap_rate (r.cap),
		.tick     (tick)
	);

	// Window and boundary from the straps caught at start-up
	always_comb
	begin
		if (r.cap)
			win_last = C_WIN_CAP;
		else if (r.tsel)
			win_last = C_WIN_LONG;
		else
			win_last = C_WIN_SHORT;
		case ({r.rsel, r.cap, r.tsel})
			3'b100:  low_bound = C_LOW_HI_SHORT;
			3'b101:  low_bound = C_LOW_HI_LONG;
			3'b110:  low_bound = C_LOW_HI_CAP;
			3'b111:  low_bound = C_LOW_HI_CAP;
			3'b000:  low_bound = C_LOW_LO_SHORT;
			3'b001:  low_bound = C_LOW_LO_LONG;
			3'b010:  low_bound = C_LOW_LO_CAP;
			default: low_bound = C_LOW_LO_CAP;
		endcase
	end

	assign trig_edge = r.sync2[SY_TRIG] && !r.trig_prev;

	always_comb
	begin
		next_r            = r;
		next_r.sync1      = {reset_pin_in, cap_mode, window_ratio_select,
			timeout_select, watchdog_trigger_in};
		next_r.sync2      = r.sync1;
		next_r.trig_prev  = r.sync2[SY_TRIG];
		next_r.viol_early = 1'b0;
		next_r.viol_late  = 1'b0;
		// Edge waits for the oscillator; a new edge before the tick merges
		// Clear before set, so an edge landing in the tick cycle is kept
		if (tick)
			next_r.pend = 1'b0;
		if (trig_edge)
			next_r.pend = 1'b1;
		case (r.st)
			ST_INIT:
			begin
				// Straps held off while another source holds the reset line
				next_r.tsel = r.sync2[SY_TSEL];
				next_r.rsel = r.sync2[SY_RSEL];
				next_r.cap  = r.sync2[SY_CAP];
				next_r.cnt  = '0;
				next_r.pend = 1'b0;
				if (r.sync2[SY_PIN])
					next_r.st = ST_FIRST;
			end
			ST_FIRST:
			begin
				if (tick)
				begin
					if (r.pend)
					begin
						next_r.cnt = '0;
						next_r.st  = ST_WATCH;
					end
					else if (r.cnt >= win_last)
					begin
						next_r.viol_late = 1'b1;
						next_r.cnt       = '0;
						next_r.st        = ST_RESET;
					end
					else
						next_r.cnt = r.cnt + CNT_W'(1);
				end
			end
			ST_WATCH:
			begin
				if (tick)
				begin
					if (r.pend && r.cnt < low_bound)
					begin
						next_r.viol_early = 1'b1;
						next_r.cnt        = '0;
						next_r.st         = ST_RESET;
					end
					else if (r.pend)
						next_r.cnt = '0;
					else if (r.cnt >= win_last)
					begin
						next_r.viol_late = 1'b1;
						next_r.cnt       = '0;
						next_r.st        = ST_RESET;
					end
					else
						next_r.cnt = r.cnt + CNT_W'(1);
				end
			end
			ST_RESET:
			begin
				// Triggers during the pulse are dropped, not carried over
				next_r.pend = 1'b0;
				if (tick)
				begin
					if (r.cnt >= C_HOLD_LAST)
					begin
						next_r.cnt = '0;
						next_r.st  = ST_INIT;
					end
					else
						next_r.cnt = r.cnt + CNT_W'(1);
				end
			end
			default:
			begin
				next_r.st  = ST_INIT;
				next_r.cnt = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			r       <= '0;
			r.st    <= ST_INIT;
			// Pin reads low until both flops hold real strap values
			r.trig_prev <= 1'b1;
		end
		else
			r <= next_r;
	end

	// Open drain: only ever drives low
	assign reset_pin_out   = 1'b0;
	assign reset_pin_oe_n  = !(r.st == ST_RESET);
	assign violation_early = r.viol_early;
	assign violation_late  = r.viol_late;
	assign first_window    = (r.st == ST_FIRST);

endmodule

/* hw/wws_pkg.sv */
// Constants and types shared by the window watchdog supervisor files.
// Assumes a 50 MHz system clock; oscillator ticks are derived from it.
package wws_pkg;

	// System clock
	localparam int CLK_PERIOD_NS  = 20;

	// Free-running watchdog oscillator, normal and capacitor-set rate
	localparam int OSC_PERIOD_NS  = 10000;
	localparam int OSC_DIV        = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAP_OSC_DIV    = OSC_DIV;

	// Fixed window timeouts in ms and in oscillator ticks
	localparam int WIN_SHORT_MS   = 250;
	localparam int WIN_LONG_MS    = 2500;
	localparam int WIN_SHORT_TICKS = (WIN_SHORT_MS * 1000) / (OSC_PERIOD_NS / 1000);
	localparam int WIN_LONG_TICKS  = (WIN_LONG_MS * 1000) / (OSC_PERIOD_NS / 1000);
	// Capacitor mode window, counted in ticks of the capacitor-set oscillator
	localparam int CAP_WIN_TICKS  = 3000;

	// Lower boundary ratios, times ten
	localparam int RATIO_HI_SHORT = 1249;
	localparam int RATIO_HI_LONG  = 1277;
	localparam int RATIO_HI_CAP   = 645;
	localparam int RATIO_LO_SHORT = 318;
	localparam int RATIO_LO_LONG  = 320;
	localparam int RATIO_LO_CAP   = 258;
	// Allowed capacitor-mode ratio spans, times ten
	localparam int RATIO_LO_CAP_MIN = 235;
	localparam int RATIO_LO_CAP_MAX = 287;
	localparam int RATIO_HI_CAP_MIN = 516;
	localparam int RATIO_HI_CAP_MAX = 927;

	// Reset pulse after a violation
	localparam int RST_HOLD_MS    = 25;
	localparam int RST_HOLD_TICKS = (RST_HOLD_MS * 1000) / (OSC_PERIOD_NS / 1000);

	// Widths
	localparam int CNT_W          = 20;
	localparam int TICK_W         = 12;

	// Synchroniser bit positions
	localparam int SY_TRIG        = 0;
	localparam int SY_TSEL        = 1;
	localparam int SY_RSEL        = 2;
	localparam int SY_CAP         = 3;
	localparam int SY_PIN         = 4;
	localparam int SY_W           = 5;

	typedef enum logic [3:0] {
		ST_INIT  = 4'h1,
		ST_FIRST = 4'h2,
		ST_WATCH = 4'h4,
		ST_RESET = 4'h8
	} wws_state_type;

	typedef struct packed {
		wws_state_type     st;
		logic [CNT_W-1:0]  cnt;
		logic [SY_W-1:0]   sync1;
		logic [SY_W-1:0]   sync2;
		logic              trig_prev;
		logic              pend;
		logic              tsel;
		logic              rsel;
		logic              cap;
		logic              viol_early;
		logic              viol_late;
	} wws_core_type;

	typedef struct packed {
		logic [TICK_W-1:0] cnt;
		logic              tick;
	} wws_tick_type;

endpackage

/* hw/wws_tick.sv */
// Free-running watchdog oscillator, modelled as a divider of clk_sys.
// Assumes the caller holds rate steady except across its own restarts.
`timescale 1ns/1ps

module wws_tick
	import wws_pkg::*;
#(
	parameter int NORM_DIV = OSC_DIV,
	parameter int CAP_DIV  = CAP_OSC_DIV
)
(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic cap_rate,
	output logic      tick
);

	initial
	begin
		if (NORM_DIV < 1 || NORM_DIV >= 2**TICK_W || CAP_DIV < 1 || CAP_DIV >= 2**TICK_W)
			$error("wws_tick: divider out of range");
	end

	localparam logic [TICK_W-1:0] NORM_LAST = TICK_W'(NORM_DIV - 1);
	localparam logic [TICK_W-1:0] CAP_LAST  = TICK_W'(CAP_DIV - 1);

	wws_tick_type r;
	wws_tick_type next_r;

	// Runs regardless of the trigger source, so phase to it is unknown
	always_comb
	begin
		next_r = r;
		next_r.tick = 1'b0;
		if (r.cnt >= (cap_rate ? CAP_LAST : NORM_LAST))
		begin
			next_r.cnt  = '0;
			next_r.tick = 1'b1;
		end
		else
			next_r.cnt = r.cnt + TICK_W'(1);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			r <= '0;
		else
			r <= next_r;
	end

	assign tick = r.tick;

endmodule

/* bench/wws_chk.sv */
// Port checker for the window watchdog supervisor.
// Assumes a pulled-up reset wire; bound to every wws_top instance.
`timescale 1ns/1ps
module wws_chk
#(
	parameter int NORM_DIV   = 4,
	parameter int HOLD_TICKS = 10
)
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic watchdog_trigger_in,
	input wire logic timeout_select,
	input wire logic window_ratio_select,
	input wire logic cap_mode,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n,
	input wire logic violation_early,
	input wire logic violation_late,
	input wire logic first_window
);
	int low_cnt;
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			low_cnt <= 0;
		else
			low_cnt <= reset_pin_oe_n ? 0 : low_cnt + 1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_pin_low_only: assert property (reset_pin_out == 1'b0)
		else $error("reset pin driven high");
	a_early_single: assert property (violation_early |=> !violation_early)
		else $error("early flag longer than one cycle");
	a_early_pulls: assert property (violation_early |-> !reset_pin_oe_n)
		else $error("early violation without reset");
	a_late_pulls: assert property (violation_late |-> !reset_pin_oe_n)
		else $error("late violation without reset");
	a_early_not_first: assert property (violation_early |-> !$past(first_window))
		else $error("lower check active in first window");
	a_pull_has_cause: assert property ($fell(reset_pin_oe_n) |-> violation_early || violation_late)
		else $error("reset pulled without violation");
	a_hold_length: assert property ($rose(reset_pin_oe_n) |->
		low_cnt >= HOLD_TICKS * NORM_DIV - 1 && low_cnt <= HOLD_TICKS * NORM_DIV + NORM_DIV + 1)
		else $error("reset pulse length wrong");
	a_refirst: assert property ($rose(reset_pin_oe_n) && reset_pin_in |-> ##[1:8] first_window)
		else $error("first window not restarted");
	a_first_leaves: assert property (first_window && $rose(watchdog_trigger_in) |-> ##[3:12] !first_window)
		else $error("trigger did not end first window");
	c_early: cover property (violation_early);
	c_late: cover property (violation_late);
	c_first: cover property ($rose(first_window));
endmodule

bind wws_top wws_chk #(.NORM_DIV(NORM_DIV), .HOLD_TICKS(HOLD_TICKS)) chk_u (
	.clk_sys(clk_sys), .rstn(rstn), .watchdog_trigger_in(watchdog_trigger_in),
	.timeout_select(timeout_select), .window_ratio_select(window_ratio_select),
	.cap_mode(cap_mode), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
	.reset_pin_oe_n(reset_pin_oe_n), .violation_early(violation_early),
	.violation_late(violation_late), .first_window(first_window));

/* bench/wws_proc.sv */
// Supervised processor model: one trigger pulse per request.
// Assumes requests at least eight clock cycles apart.
`timescale 1ns/1ps
module wws_proc
(
	input  wire logic clk_sys,
	input  wire logic fire,
	output logic      trig
);
	logic [2:0] hold = 3'h0;
	// Raised and dropped at separate points, three cycles high
	always_ff @(posedge clk_sys)
		hold <= fire ? 3'h3 : ((hold != 3'h0) ? hold - 3'h1 : 3'h0);
	assign trig = hold != 3'h0;
endmodule

/* bench/test_window_watchdog_supervisor.sv */
// Self-checking bench for the window watchdog supervisor.
// Assumes shortened tick counts; reset wire pulled up here.
`timescale 1ns/1ps
module test_window_watchdog_supervisor
	import wws_pkg::*;
;
	localparam int DIV  = 4;
	localparam int HOLD = 10;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic tsel = 1'b0, rsel = 1'b0, cap = 1'b0, fire = 1'b0;
	logic trig, oe_n, pin_out, v_early, v_late, fw, pin_in;
	int mismatches = 0, compares = 0, n_early = 0, n_late = 0;
	always #10 clk_sys = ~clk_sys;
	assign pin_in = oe_n ? 1'b1 : pin_out;
	always @(posedge clk_sys)
	begin
		n_early += (v_early === 1'b1);
		n_late += (v_late === 1'b1);
	end
	wws_proc proc_u (.clk_sys(clk_sys), .fire(fire), .trig(trig));
	wws_top #(.NORM_DIV(DIV), .CAP_DIV(DIV), .SHORT_TICKS(400), .LONG_TICKS(800),
		.CAP_TICKS(300), .HOLD_TICKS(HOLD)) dut_u (
		.clk_sys(clk_sys), .rstn(rstn), .watchdog_trigger_in(trig),
		.timeout_select(tsel), .window_ratio_select(rsel), .cap_mode(cap),
		.reset_pin_in(pin_in), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
		.violation_early(v_early), .violation_late(v_late), .first_window(fw));

	function automatic int win_of(logic t, logic c);
		return c ? 300 : (t ? 800 : 400);
	endfunction
	function automatic int lb_of(logic t, logic r, logic c);
		int q;
		if (c)
			q = r ? RATIO_HI_CAP : RATIO_LO_CAP;
		else if (r)
			q = t ? RATIO_HI_LONG : RATIO_HI_SHORT;
		else
			q = t ? RATIO_LO_LONG : RATIO_LO_SHORT;
		return win_of(t, c) * 10 / q;
	endfunction
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Whole ticks per call keep every edge at one tick phase
	task automatic pulse_after(int ticks);
		cyc(ticks * DIV - 1);
		fire = 1'b1;
		cyc(1);
		fire = 1'b0;
	endtask
	task automatic wait_fw();
		for (int i = 0; i < 60 && fw !== 1'b1; i++)
			cyc(1);
		check("first window", fw, 1'b1);
	endtask
	task automatic run_cfg(logic t, logic r, logic c);
		int win, lb, e0, l0, lo;
		win = win_of(t, c);
		lb = lb_of(t, r, c);
		rstn = 1'b0;
		tsel = t;
		rsel = r;
		cap = c;
		cyc(16);
		rstn = 1'b1;
		wait_fw();
		e0 = n_early;
		pulse_after(1);
		pulse_after(lb + 2 + $urandom % (win - lb - 6));
		pulse_after(lb + 2);
		pulse_after((lb > 4) ? lb - 2 : 2);
		check("early none", n_early, e0);
		lo = 0;
		for (int i = 0; i < 200 && !(lo > 0 && oe_n === 1'b1); i++)
		begin
			lo += (oe_n === 1'b0);
			cyc(1);
		end
		check("early count", n_early, e0 + 1);
		check("hold span", lo >= HOLD * DIV - 1 && lo <= HOLD * DIV + DIV + 1, 1);
		wait_fw();
		l0 = n_late;
		pulse_after(1);
		cyc((win - 2) * DIV);
		check("late too soon", n_late, l0);
		cyc(3 * DIV + 12);
		check("late count", n_late, l0 + 1);
		check("late no early", n_early, e0 + 1);
	endtask

	initial
	begin
		void'($urandom(32'h53EEF7FD));
		for (int k = 0; k < 6; k++)
			run_cfg((k >= 4) ? 1'($urandom % 2) : 1'(k >> 1), 1'(k), k >= 4);
		print_verdict();
	end
	initial
	begin
		#(80000 * 20);
		mismatches++;
		print_verdict();
	end
endmodule
